/* hdl/core_pkg.sv */
package core_pkg;
  localparam int unsigned CLKS_PER_CYCLE = 4;
  localparam int unsigned PHASE_W        = 2;
  localparam int unsigned ADDR_W         = 11;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned STACK_DEPTH    = 8;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 11'h000;
  localparam logic [6:0] PC_LOW_ADDR = 7'h06;

  // instruction word: [15:11] class, [10:8] bit/sub, [7:0] operand
  typedef enum logic [4:0] {
    nop_op, move_op, move_to_mem_op, move_imm_op,
    add_op, add_imm_op, sub_op, sub_imm_op,
    increment_in_place_op, increment_to_acc_op,
    decrement_in_place_op, decrement_to_acc_op,
    and_op, or_op, xor_op, complement_op,
    rotate_right_op, rotate_left_op,
    rotate_right_through_carry_op, rotate_left_through_carry_op,
    bit_set_op, bit_clear_op, skip_bit_clear_op, skip_bit_set_op,
    skip_zero_op, jump_op, call_op, subroutine_return_op,
    interrupt_return_op, table_read_op, halt_op, watchdog_clear_op
  } opclass_t;

  typedef struct packed {
    opclass_t         op;
    logic [2:0]       sub;
    logic [7:0]       operand;
  } instr_t;

  typedef struct packed {
    logic             we;
    logic [6:0]       addr;
    logic [DATA_W-1:0] wdata;
  } dmem_req_t;
endpackage : core_pkg

/* hdl/return_stack.sv */
`timescale 1ns/1ps
`default_nettype none
// small lifo of return addresses; read data is registered top of stack
module return_stack #(
  parameter int unsigned DEPTH = core_pkg::STACK_DEPTH,
  parameter int unsigned WIDTH = core_pkg::ADDR_W
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    ptr_q, ptr_d;
  logic [WIDTH-1:0] top_q, top_d;

  always_comb begin
    ptr_d = ptr_q;
    top_d = top_q;
    if (push) begin
      ptr_d = ptr_q + 1'b1;
      top_d = push_data;
    end else if (pop) begin
      ptr_d = ptr_q - 1'b1;
      top_d = mem_q[ptr_q - 1'b1];
    end
  end

  // overflow wraps silently, as a circular stack would
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_q <= '0;
      top_q <= '0;
    end else begin
      ptr_q <= ptr_d;
      top_q <= top_d;
      if (push)
        mem_q[ptr_q] <= top_q;
    end
  end

  assign top = top_q;
endmodule : return_stack
`default_nettype wire

/* hdl/instr_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - ordinary instructions take one cycle; jump, call, return and table read take two.
// - each instruction cycle lasts four system clocks.
// - writing the low program counter byte redirects fetch and costs one extra cycle.
// - a skip test costs one cycle, plus one more when the skip is taken.
// - add reports carry above 255 and subtract reports borrow below 0.
// - increment and decrement change the operand by one, to memory or accumulator.
// - logical operations via the accumulator set zero when the result is zero.
// - rotates move one bit; through-carry forms swap the leaving bit with carry.
// - call saves the next address and return resumes there; jump saves nothing.
// - conditional branches test a byte or bit and run or skip the next instruction.
// - bit set and clear change only the addressed bit by read-modify-write.
// - table read fetches constant program memory data into a data register.
// - moves cover register to accumulator, accumulator to register and immediate.
// - halt enters power-down and a watchdog service instruction exists.
module instr_sequencer (
  input  wire logic                       clk,
  input  wire logic                       reset,
  output logic      [core_pkg::ADDR_W-1:0] pmem_addr,
  input  wire core_pkg::instr_t           pmem_data,
  output core_pkg::dmem_req_t             dmem_req,
  input  wire logic [core_pkg::DATA_W-1:0] dmem_rdata,
  output logic      [core_pkg::DATA_W-1:0] acc,
  output logic                            carry,
  output logic                            zero,
  output logic                            halted,
  output logic                            watchdog_clear,
  output logic                            cycle_strobe
);
  localparam int unsigned AW = core_pkg::ADDR_W;
  localparam int unsigned DW = core_pkg::DATA_W;
  typedef enum {exec_st, flush_st, table_st, halt_st} seq_t;

  logic [core_pkg::PHASE_W-1:0] phase_q, phase_d;
  seq_t                         st_q, st_d;
  logic [AW-1:0]                pc_q, pc_d;
  logic [DW-1:0]                acc_q, acc_d;
  logic                         c_q, c_d, z_q, z_d;
  core_pkg::dmem_req_t          req_q, req_d;
  logic                         wdt_q, wdt_d;
  logic                         push, pop, tick;
  logic [AW-1:0]                ret_top;
  core_pkg::instr_t             ins;
  logic [DW:0]                  sum;
  logic [DW-1:0]                res;
  logic [DW-1:0]                bitmask;

  assign ins  = pmem_data;
  // advance once per four system clocks
  assign tick = (phase_q == core_pkg::PHASE_W'(core_pkg::CLKS_PER_CYCLE - 1));

  always_comb begin
    phase_d = tick ? '0 : phase_q + 1'b1;
  end

  always_comb begin
    st_d    = st_q;
    pc_d    = pc_q;
    acc_d   = acc_q;
    c_d     = c_q;
    z_d     = z_q;
    req_d   = req_q;
    req_d.we = 1'b0;
    wdt_d   = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    sum     = '0;
    res     = '0;
    bitmask = DW'(1) << ins.sub;
    if (tick) begin
      case (st_q)
        exec_st: begin
          pc_d = pc_q + 1'b1;
          case (ins.op)
            core_pkg::move_op: acc_d = dmem_rdata;
            core_pkg::move_imm_op: acc_d = ins.operand;
            core_pkg::move_to_mem_op: res = acc_q;
            core_pkg::add_op, core_pkg::add_imm_op: begin
              sum = {1'b0, acc_q} + {1'b0, (ins.op == core_pkg::add_op)
                    ? dmem_rdata : ins.operand};
              acc_d = sum[DW-1:0];
              c_d   = sum[DW]; // carry when sum exceeds 255
              z_d   = (sum[DW-1:0] == '0);
            end
            core_pkg::sub_op, core_pkg::sub_imm_op: begin
              sum = {1'b0, acc_q} - {1'b0, (ins.op == core_pkg::sub_op)
                    ? dmem_rdata : ins.operand};
              acc_d = sum[DW-1:0];
              c_d   = ~sum[DW]; // carry low means borrow below 0
              z_d   = (sum[DW-1:0] == '0);
            end
            core_pkg::increment_in_place_op,
            core_pkg::increment_to_acc_op: begin
              res = dmem_rdata + 1'b1;
              z_d = (res == '0);
              if (ins.op == core_pkg::increment_to_acc_op)
                acc_d = res;
            end
            core_pkg::decrement_in_place_op,
            core_pkg::decrement_to_acc_op: begin
              res = dmem_rdata - 1'b1;
              z_d = (res == '0);
              if (ins.op == core_pkg::decrement_to_acc_op)
                acc_d = res;
            end
            core_pkg::and_op, core_pkg::or_op, core_pkg::xor_op,
            core_pkg::complement_op: begin
              case (ins.op)
                core_pkg::and_op: acc_d = acc_q & dmem_rdata;
                core_pkg::or_op:  acc_d = acc_q | dmem_rdata;
                core_pkg::xor_op: acc_d = acc_q ^ dmem_rdata;
                default:          acc_d = ~acc_q;
              endcase
              z_d = (acc_d == '0);
            end
            core_pkg::rotate_right_op:
              acc_d = {acc_q[0], acc_q[DW-1:1]};
            core_pkg::rotate_left_op:
              acc_d = {acc_q[DW-2:0], acc_q[DW-1]};
            core_pkg::rotate_right_through_carry_op: begin
              acc_d = {c_q, acc_q[DW-1:1]};
              c_d   = acc_q[0];
            end
            core_pkg::rotate_left_through_carry_op: begin
              acc_d = {acc_q[DW-2:0], c_q};
              c_d   = acc_q[DW-1];
            end
            core_pkg::bit_set_op: res = dmem_rdata | bitmask;
            core_pkg::bit_clear_op: res = dmem_rdata & ~bitmask;
            // a taken skip steps over the next word; the flush slot then
            // holds the word after it, so nothing runs twice
            core_pkg::skip_bit_clear_op:
              if ((dmem_rdata & bitmask) == '0) begin
                pc_d = pc_q + AW'(2);
                st_d = flush_st;
              end
            core_pkg::skip_bit_set_op:
              if ((dmem_rdata & bitmask) != '0) begin
                pc_d = pc_q + AW'(2);
                st_d = flush_st;
              end
            core_pkg::skip_zero_op:
              if (dmem_rdata == '0) begin
                pc_d = pc_q + AW'(2);
                st_d = flush_st;
              end
            core_pkg::jump_op: begin
              pc_d = {ins.sub, ins.operand}; // nothing saved
              st_d = flush_st;
            end
            core_pkg::call_op: begin
              push = 1'b1; // saves address after the call
              pc_d = {ins.sub, ins.operand};
              st_d = flush_st;
            end
            core_pkg::subroutine_return_op,
            core_pkg::interrupt_return_op: begin
              pop  = 1'b1;
              pc_d = ret_top;
              st_d = flush_st;
            end
            core_pkg::table_read_op: begin
              pc_d = {ins.sub, acc_q}; // table page from sub, index in acc
              st_d = table_st;
            end
            core_pkg::halt_op: begin
              st_d = halt_st;
              pc_d = pc_q;
            end
            core_pkg::watchdog_clear_op: wdt_d = 1'b1;
            default: ;
          endcase
          // destinations that write data memory
          case (ins.op)
            core_pkg::move_to_mem_op, core_pkg::increment_in_place_op,
            core_pkg::decrement_in_place_op, core_pkg::bit_set_op,
            core_pkg::bit_clear_op: begin
              req_d.we    = 1'b1;
              req_d.wdata = res;
              if (ins.operand[6:0] == core_pkg::PC_LOW_ADDR) begin
                req_d.we = 1'b0;
                pc_d = {pc_q[AW-1:DW], res};
                st_d = flush_st;
              end
            end
            default: ;
          endcase
        end
        // fetched word is discarded; no state changes here
        flush_st: st_d = exec_st;
        table_st: begin
          req_d.we    = 1'b1;
          req_d.wdata = ins.operand;
          pc_d = ret_top;
          pop  = 1'b1;
          st_d = exec_st;
        end
        // power-down: only reset leaves this state
        halt_st: st_d = halt_st;
        default: st_d = exec_st;
      endcase
    end
    if (tick && st_q == exec_st && ins.op == core_pkg::table_read_op)
      push = 1'b1; // park return address for the data fetch
    if (tick && st_q == exec_st)
      req_d.addr = ins.operand[6:0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= '0;
      st_q    <= exec_st;
      pc_q    <= core_pkg::RESET_VECTOR;
      acc_q   <= '0;
      c_q     <= 1'b0;
      z_q     <= 1'b0;
      req_q   <= '0;
      wdt_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      st_q    <= st_d;
      pc_q    <= pc_d;
      acc_q   <= acc_d;
      c_q     <= c_d;
      z_q     <= z_d;
      req_q   <= req_d;
      wdt_q   <= wdt_d;
    end
  end

  return_stack #(
    .DEPTH (core_pkg::STACK_DEPTH),
    .WIDTH (AW)
  ) u_stack (
    .clk       (clk),
    .reset     (reset),
    .push      (push),
    .pop       (pop),
    .push_data (pc_q + 1'b1),
    .top       (ret_top)
  );

  assign pmem_addr      = pc_q;
  assign dmem_req       = req_q;
  assign acc            = acc_q;
  assign carry          = c_q;
  assign zero           = z_q;
  assign halted         = (st_q == halt_st);
  assign watchdog_clear = wdt_q;
  assign cycle_strobe   = tick;
endmodule : instr_sequencer
`default_nettype wire

/* tb/instr_sequencer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module instr_sequencer_monitor (
  input wire logic                        clk,
  input wire logic                        reset,
  input wire logic [core_pkg::ADDR_W-1:0] pmem_addr,
  input wire core_pkg::instr_t            pmem_data,
  input wire core_pkg::dmem_req_t         dmem_req,
  input wire logic [core_pkg::DATA_W-1:0] dmem_rdata,
  input wire logic [core_pkg::DATA_W-1:0] acc,
  input wire logic                        carry,
  input wire logic                        zero,
  input wire logic                        halted,
  input wire logic                        watchdog_clear,
  input wire logic                        cycle_strobe
);
  // only words after a plain data op are surely executed, so checks
  // are gated by that; flow changes and pc-low writes may flush
  logic live_q;
  logic live_d;
  logic go;
  always_comb begin
    live_d = live_q;
    if (cycle_strobe) begin
      live_d = pmem_data.op < core_pkg::skip_bit_clear_op &&
               pmem_data.operand[6:0] != core_pkg::PC_LOW_ADDR;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) live_q <= 1'b1;
    else live_q <= live_d;
  end
  // the sync reset lands one edge after it is seen, so checks stay off
  // for that edge as well
  logic rst_q;
  always_ff @(posedge clk) begin
    rst_q <= reset;
  end
  assign go = cycle_strobe && live_q && !halted;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset || rst_q);
  AST_STROBE: assert property (
    cycle_strobe ##1 !halted |-> !cycle_strobe [*3] ##1 cycle_strobe)
    else $error("cycle is not four clocks");
  AST_ACC_HOLD: assert property (
    !cycle_strobe |=> $stable(acc) && $stable(carry) && $stable(zero))
    else $error("state moved between ticks");
  AST_WD: assert property (
    watchdog_clear |-> $past(cycle_strobe) &&
      $past(pmem_data.op) == core_pkg::watchdog_clear_op)
    else $error("stray watchdog pulse");
  AST_HALT: assert property (
    halted |=> halted && $stable(acc))
    else $error("halt did not hold");
  AST_INC: assert property (
    go && pmem_data.op == core_pkg::increment_to_acc_op
      |=> acc == $past(dmem_rdata) + 8'h01)
    else $error("increment wrong");
  AST_ADD: assert property (
    go && pmem_data.op == core_pkg::add_imm_op |=> {carry, acc} ==
      {1'b0, $past(acc)} + {1'b0, $past(pmem_data.operand)})
    else $error("add carry wrong");
  AST_AND: assert property (
    go && pmem_data.op == core_pkg::and_op |=> zero == (acc == 8'h00)
      && acc == ($past(acc) & $past(dmem_rdata)))
    else $error("logic zero wrong");
  AST_BITCLR: assert property (
    go && pmem_data.op == core_pkg::bit_clear_op |=> dmem_req.we &&
      dmem_req.addr == $past(pmem_data.operand[6:0]) && dmem_req.wdata ==
      ($past(dmem_rdata) & ~(8'h01 << $past(pmem_data.sub))))
    else $error("bit clear wrong");
  AST_SKIP: assert property (
    go && pmem_data.op == core_pkg::skip_zero_op && dmem_rdata == 8'h00
      |-> ##5 acc == $past(acc, 5) && carry == $past(carry, 5))
    else $error("skipped slot changed state");
  CV_JUMP: cover property (go && pmem_data.op == core_pkg::jump_op);
  CV_HALT: cover property ($rose(halted));
  CV_WE: cover property (dmem_req.we);
endmodule : instr_sequencer_monitor
bind instr_sequencer instr_sequencer_monitor mon (
  .clk(clk), .reset(reset), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
  .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .acc(acc), .carry(carry),
  .zero(zero), .halted(halted), .watchdog_clear(watchdog_clear),
  .cycle_strobe(cycle_strobe));
`default_nettype wire

/* tb/program_store.sv */
`timescale 1ns/1ps
`default_nettype none
// program and data store, both read combinationally as the core expects
module program_store (
  input  wire logic                        clk,
  input  wire logic [core_pkg::ADDR_W-1:0] pmem_addr,
  input  wire core_pkg::dmem_req_t         dmem_req,
  output core_pkg::instr_t                 pmem_data,
  output logic      [core_pkg::DATA_W-1:0] dmem_rdata
);
  core_pkg::instr_t rom [2048];
  logic [7:0]       ram [128];
  assign pmem_data  = rom[pmem_addr];
  assign dmem_rdata = ram[pmem_data.operand[6:0]];
  always @(posedge clk)
    if (dmem_req.we) ram[dmem_req.addr] <= dmem_req.wdata;
endmodule : program_store
`default_nettype wire

/* tb/mcu_instruction_timing_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_timing_tb_top;
  typedef struct packed {
    core_pkg::instr_t i;
    logic [7:0]       a;
    logic             c;
  } row_t;
  logic                        clk = 1'b0;
  logic                        reset = 1'b1;
  logic [core_pkg::ADDR_W-1:0] pmem_addr;
  core_pkg::instr_t            pmem_data;
  core_pkg::dmem_req_t         dmem_req;
  logic [7:0]                  dmem_rdata;
  logic [7:0]                  acc;
  logic                        carry, zero, halted, watchdog_clear, cycle_strobe;
  int                          mismatches = 0, tests_run = 0, wd_n = 0, last_k;
  row_t                        rows [15];
  logic [7:0]                  hand [21];
  always #5 clk = ~clk;
  always @(posedge clk) if (watchdog_clear === 1'b1) wd_n <= wd_n + 1;
  instr_sequencer uut (.clk(clk), .reset(reset), .pmem_addr(pmem_addr),
    .pmem_data(pmem_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .acc(acc), .carry(carry), .zero(zero), .halted(halted),
    .watchdog_clear(watchdog_clear), .cycle_strobe(cycle_strobe));
  program_store pm (.clk(clk), .pmem_addr(pmem_addr), .dmem_req(dmem_req),
    .pmem_data(pmem_data), .dmem_rdata(dmem_rdata));
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic check(string what, logic [10:0] seen, logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick();
    last_k = 0;
    // strobe is looked at mid-cycle, away from the edge that moves it
    do begin
      @(negedge clk);
      last_k++;
    end while (cycle_strobe !== 1'b1 && last_k < 9);
    if (last_k >= 9) begin
      mismatches++;
      wrap_up();
    end
    @(posedge clk);
    #1;
  endtask : tick
  task automatic p(int a, core_pkg::opclass_t op, logic [2:0] s,
                   logic [7:0] d);
    pm.rom[a] = '{op, s, d};
  endtask : p
  function automatic row_t r(core_pkg::opclass_t op, logic [2:0] s,
                             logic [7:0] d, logic [7:0] a, logic c);
    return '{'{op, s, d}, a, c};
  endfunction : r
  initial begin
    for (int j = 0; j < 2048; j++) pm.rom[j] = '0;
    for (int j = 0; j < 128; j++) pm.ram[j] = 8'h00;
    pm.ram[16] = 8'h81;
    rows[0] = r(core_pkg::move_imm_op, 3'h0, 8'hff, 8'hff, 1'b0);
    rows[1] = r(core_pkg::add_imm_op, 3'h0, 8'h01, 8'h00, 1'b1);
    rows[2] = r(core_pkg::sub_imm_op, 3'h0, 8'h06, 8'hfa, 1'b0);
    rows[3] = r(core_pkg::move_op, 3'h0, 8'h10, 8'h81, 1'b0);
    rows[4] = r(core_pkg::increment_to_acc_op, 3'h0, 8'h10, 8'h82, 1'b0);
    rows[5] = r(core_pkg::decrement_to_acc_op, 3'h0, 8'h11, 8'hff, 1'b0);
    rows[6] = r(core_pkg::and_op, 3'h0, 8'h11, 8'h00, 1'b0);
    rows[7] = r(core_pkg::xor_op, 3'h0, 8'h10, 8'h81, 1'b0);
    rows[8] = r(core_pkg::rotate_left_through_carry_op, 3'h0, 8'h10, 8'h02,
                1'b1);
    rows[9] = r(core_pkg::bit_clear_op, 3'h7, 8'h10, 8'h02, 1'b1);
    rows[10] = r(core_pkg::bit_set_op, 3'h7, 8'h11, 8'h02, 1'b1);
    rows[11] = r(core_pkg::move_op, 3'h0, 8'h11, 8'h80, 1'b1);
    rows[12] = r(core_pkg::move_to_mem_op, 3'h0, 8'h12, 8'h80, 1'b1);
    rows[13] = r(core_pkg::decrement_in_place_op, 3'h0, 8'h12, 8'h80, 1'b1);
    rows[14] = r(core_pkg::add_op, 3'h0, 8'h12, 8'hff, 1'b0);
    foreach (rows[i]) pm.rom[i] = rows[i].i;
    p(15, core_pkg::jump_op, 3'h0, 8'h20);
    p(32, core_pkg::move_imm_op, 3'h0, 8'h33);
    p(33, core_pkg::call_op, 3'h0, 8'h30);
    p(34, core_pkg::move_imm_op, 3'h0, 8'h55);
    p(48, core_pkg::move_imm_op, 3'h0, 8'h44);
    p(49, core_pkg::subroutine_return_op, 3'h0, 8'h00);
    p(35, core_pkg::skip_zero_op, 3'h0, 8'h14);
    p(36, core_pkg::move_imm_op, 3'h0, 8'h66);
    p(37, core_pkg::skip_bit_set_op, 3'h0, 8'h14);
    p(38, core_pkg::move_imm_op, 3'h0, 8'h40);
    p(39, core_pkg::move_to_mem_op, 3'h0, 8'h06);
    p(64, core_pkg::move_imm_op, 3'h0, 8'h50);
    p(65, core_pkg::table_read_op, 3'h0, 8'h13);
    p(80, core_pkg::nop_op, 3'h0, 8'ha5);
    p(66, core_pkg::move_op, 3'h0, 8'h13);
    p(67, core_pkg::watchdog_clear_op, 3'h0, 8'h00);
    p(68, core_pkg::halt_op, 3'h0, 8'h00);
    p(69, core_pkg::move_imm_op, 3'h0, 8'h01);
    // flush slots repeat the previous value
    hand = '{8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h44, 8'h44, 8'h44,
             8'h55, 8'h55, 8'h55, 8'h55, 8'h40, 8'h40, 8'h40, 8'h50,
             8'h50, 8'h50, 8'ha5, 8'ha5, 8'ha5};
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("pc", pmem_addr, 11'h000);
    check("acc", acc, 8'h00);
    foreach (rows[i]) begin
      tick();
      if (i > 0) check("spacing", last_k[10:0], 11'h004);
      check("acc", acc, rows[i].a);
      check("carry", carry, rows[i].c);
      if (i == 6) check("zero", zero, 1'b1);
    end
    check("bitclr", pm.ram[16], 8'h01);
    check("decmem", pm.ram[18], 8'h7f);
    foreach (hand[i]) begin
      tick();
      check("acc", acc, hand[i]);
    end
    check("wd", wd_n[10:0], 11'h001);
    check("halted", halted, 1'b1);
    repeat (12) @(posedge clk);
    #1;
    check("acc", acc, 8'ha5);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    check("halted", halted, 1'b0);
    check("pc", pmem_addr, 11'h000);
    check("acc", acc, 8'h00);
    tick();
    check("spacing", last_k[10:0], 11'h004);
    check("acc", acc, 8'hff);
    wrap_up();
  end
endmodule : mcu_instruction_timing_tb_top
`default_nettype wire
